/* hdl/sram_port_pkg.sv */
// constants and types for the pipelined synchronous sram port
// assumes a single 100 MHz clock and a synchronous host on the pins
package sram_port_pkg;
  localparam int ADDR_W      = 19;
  localparam int LANE_W      = 9;
  localparam int LANES       = 2;
  localparam int WORD_W      = LANE_W * LANES;
  localparam int BURST_W     = 2;
  localparam int MEM_W       = 6;
  localparam int PIPE_DEPTH  = 2;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic [ADDR_W-1:0]  ADDR_RST  = 19'h00000;
  localparam logic [WORD_W-1:0]  WORD_RST  = 18'h00000;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } op_e;

  // next burst address offset: interleaved xors, linear adds
  function automatic logic [BURST_W-1:0] burst_next(
    input logic [BURST_W-1:0] start,
    input logic [BURST_W-1:0] count,
    input logic               interleaved
  );
    logic [BURST_W-1:0] n;
    n = count + 2'h1;
    if (interleaved) begin
      burst_next = start ^ n;
    end else begin
      burst_next = start + n;
    end
  endfunction : burst_next
endpackage : sram_port_pkg

/* hdl/sram_stage_if.sv */
// carrier between the port and its storage array
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface sram_stage_if;
  import sram_port_pkg::*;
  logic                 wr_en;
  logic [LANES-1:0]     lane_en;
  logic [MEM_W-1:0]     addr;
  logic [WORD_W-1:0]    wdata;
  logic [WORD_W-1:0]    rdata;
  modport ctrl (output wr_en, output lane_en, output addr, output wdata, input rdata);
  modport mem  (input wr_en, input lane_en, input addr, input wdata, output rdata);
endinterface : sram_stage_if
`default_nettype wire

/* hdl/sram_array.sv */
// flip-flop storage array with per-lane write enables
// assumes the controller drives one access a cycle
`timescale 1ns/1ps
`default_nettype none
module sram_array
  import sram_port_pkg::*;
(
  // clock
  input  wire logic clk_sys_i,
  // access
  sram_stage_if.mem st
);
  logic [WORD_W-1:0] mem_q [2**MEM_W];

  always_ff @(posedge clk_sys_i) begin
    if (st.wr_en) begin
      for (int l = 0; l < LANES; l++) begin
        if (st.lane_en[l]) begin
          mem_q[st.addr][l*LANE_W +: LANE_W] <= st.wdata[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  assign st.rdata = mem_q[st.addr];
endmodule : sram_array
`default_nettype wire

/* hdl/sram_port.sv */
// pipelined synchronous sram port: address/control pipeline, burst, data pins
// assumes host pins are synchronous to clk_sys_i; mode pin is static
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// - data in and out pass registers on rising clock edge
// - address loads only with load low, suspend low, all selects true
// - burst counter starts from two address lsbs
// - one active-low write enable per nine-bit lane
// - lane enables ignored on read cycles
// - enabled lanes stored two cycles after sampling
// - first enable gates lower lane, second gates upper lane
// - suspend high freezes all registers and outputs
// - suspended edge acts as if it never happened
// - load direction holds for burst; data moves two cycles later
// - advance steps burst counter, ignores address and direction
// - mode high selects interleaved, low selects linear order
// - deselect floats data bus two cycles later
module sram_port
  import sram_port_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  // control
  input  wire logic              clock_suspend_n_i,
  input  wire logic              advance_or_load_n_i,
  input  wire logic              write_n_i,
  input  wire logic              chip_select_n_i,
  input  wire logic              chip_select_hi_i,
  input  wire logic              chip_select_alt_n_i,
  input  wire logic              burst_interleaved_i,
  // address and lane enables
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              lane0_byte_write_n_i,
  input  wire logic              lane1_byte_write_n_i,
  // data pins
  input  wire logic [LANE_W-1:0] lane0_data_i,
  input  wire logic [LANE_W-1:0] lane1_data_i,
  output logic      [LANE_W-1:0] lane0_data_o,
  output logic      [LANE_W-1:0] lane1_data_o,
  output logic                   data_oe_n_o
);
  //////////////////////////////////////////////////////////////////////////////
  // stage 0: sampled controls
  logic              run;
  logic              sel;
  logic              load;
  logic              adv;
  op_e               op_q;
  logic [ADDR_W-1:0] base_q;
  logic [BURST_W-1:0] cnt_q;
  logic [BURST_W-1:0] nxt_lsb;
  logic [ADDR_W-1:0] nxt_addr;
  logic [LANES-1:0]  lane_en;
  op_e               s1_op_q;
  op_e               s2_op_q;
  logic [ADDR_W-1:0] s1_addr_q;
  logic [ADDR_W-1:0] s2_addr_q;
  logic [LANES-1:0]  s1_lane_q;
  logic [LANES-1:0]  s2_lane_q;
  logic [WORD_W-1:0] dout_q;
  logic              oe_n_q;

  sram_stage_if st ();

  assign run  = ~clock_suspend_n_i;
  assign sel  = ~chip_select_n_i & chip_select_hi_i & ~chip_select_alt_n_i;
  assign load = run & ~advance_or_load_n_i;
  assign adv  = run & advance_or_load_n_i;
  // lane 0 low half, lane 1 high half
  assign lane_en = {~lane1_byte_write_n_i, ~lane0_byte_write_n_i};

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_q <= ADDR_RST;
      cnt_q  <= BURST_RST;
    end else if (load && sel) begin
      base_q <= addr_i;
      cnt_q  <= BURST_RST;
    end else if (adv && op_q != OP_IDLE) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  // direction fixed at load; deselect stops the burst
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_q <= OP_IDLE;
    end else if (load) begin
      op_q <= !sel ? OP_IDLE : (write_n_i ? OP_READ : OP_WRITE);
    end
  end

  // next beat offset, order from mode input
  assign nxt_lsb  = burst_next(base_q[BURST_W-1:0], cnt_q, burst_interleaved_i);
  assign nxt_addr = {base_q[ADDR_W-1:BURST_W], nxt_lsb};

  //////////////////////////////////////////////////////////////////////////////
  // pipeline: stage 1 is the sampled cycle, stage 2 the data cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_op_q   <= OP_IDLE;
      s1_addr_q <= ADDR_RST;
      s1_lane_q <= '0;
      s2_op_q   <= OP_IDLE;
      s2_addr_q <= ADDR_RST;
      s2_lane_q <= '0;
    end else if (run) begin
      if (load) begin
        s1_op_q   <= !sel ? OP_IDLE : (write_n_i ? OP_READ : OP_WRITE);
        s1_addr_q <= addr_i;
      end else begin
        s1_op_q   <= op_q;
        s1_addr_q <= nxt_addr;
      end
      s1_lane_q <= (load ? write_n_i : op_q != OP_WRITE) ? '0 : lane_en;
      s2_op_q   <= s1_op_q;
      s2_addr_q <= s1_addr_q;
      s2_lane_q <= s1_lane_q;
    end
  end

  // write two cycles after sampling, data captured with stage 2
  assign st.wr_en   = run && s2_op_q == OP_WRITE;
  assign st.lane_en = s2_lane_q;
  // reads and writes share stage 2, so a read right after a write sees it
  assign st.addr    = s2_addr_q[MEM_W-1:0];
  // array flops register the pins at the write edge
  assign st.wdata   = {lane1_data_i, lane0_data_i};

  sram_array u_array (
    .clk_sys_i (clk_sys_i),
    .st        (st)
  );

  // registered read data and bus float
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dout_q <= WORD_RST;
      oe_n_q <= 1'b1;
    end else if (run) begin
      oe_n_q <= s2_op_q != OP_READ;
      if (s2_op_q == OP_READ) begin
        dout_q <= st.rdata;
      end
    end
  end

  assign lane0_data_o = dout_q[LANE_W-1:0];
  assign lane1_data_o = dout_q[WORD_W-1:LANE_W];
  assign data_oe_n_o  = oe_n_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_suspend_holds_out: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !run |=> $stable(dout_q) && $stable(oe_n_q))
    else $error("output changed on suspended edge");
  a_suspend_holds_cnt: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !run |=> $stable(cnt_q) && $stable(base_q) && $stable(s1_op_q))
    else $error("state changed while suspended");
  a_load_takes_addr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    load && sel |=> base_q == $past(addr_i) && cnt_q == 2'h0)
    else $error("address not loaded");
  a_noload_keeps_addr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !(load && sel) |=> $stable(base_q))
    else $error("address changed without load");
  a_read_drops_en: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    load && sel && write_n_i |=> s1_lane_q == 2'h0)
    else $error("lane enables kept on read");
  a_write_two_later: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    load && sel && !write_n_i ##1 run ##1 run |-> st.wr_en)
    else $error("write not issued two cycles later");
  a_read_drives_bus: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    load && sel && write_n_i ##1 run ##1 run |=> !data_oe_n_o)
    else $error("read data not driven");
  a_deselect_floats: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    load && !sel ##1 run ##1 run |=> data_oe_n_o)
    else $error("bus not floated after deselect");
  a_burst_steps: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    adv && op_q != OP_IDLE |=> cnt_q == $past(cnt_q) + 2'h1)
    else $error("burst counter did not step");

  //////////////////////////////////////////////////////////////////////////////
  // burst order, lane, float and suspend checks
  a_adv_keeps_dir: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    adv |=> op_q == $past(op_q))
    else $error("direction changed on advance");
  a_adv_keeps_base: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    adv |=> s1_addr_q[ADDR_W-1:BURST_W] == $past(base_q[ADDR_W-1:BURST_W]))
    else $error("external address used on advance");
  a_deselect_stops: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    load && !sel |=> op_q == OP_IDLE && s1_op_q == OP_IDLE)
    else $error("burst not stopped by deselect");
  a_idle_adv_nop: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    adv && op_q == OP_IDLE |=> s1_op_q == OP_IDLE && $stable(cnt_q))
    else $error("advance acted with no burst");
  a_lane_map: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    load && sel && !write_n_i |=>
      s1_lane_q == {~$past(lane1_byte_write_n_i), ~$past(lane0_byte_write_n_i)})
    else $error("lane enables mapped wrongly");
  a_first_beat: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    load && sel |=> s1_addr_q[BURST_W-1:0] == $past(addr_i[BURST_W-1:0]))
    else $error("burst did not start at address lsbs");
  a_linear_order: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    adv && op_q != OP_IDLE && !burst_interleaved_i |=>
      s1_addr_q[BURST_W-1:0] == $past(base_q[BURST_W-1:0]) + $past(cnt_q) + 2'h1)
    else $error("linear burst order wrong");
  a_interleaved_order: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    adv && op_q != OP_IDLE && burst_interleaved_i |=>
      s1_addr_q[BURST_W-1:0] == ($past(base_q[BURST_W-1:0]) ^ ($past(cnt_q) + 2'h1)))
    else $error("interleaved burst order wrong");
  a_write_floats: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    load && sel && !write_n_i ##1 run ##1 run |=> data_oe_n_o)
    else $error("bus driven during write");
  a_suspend_no_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !run |-> !st.wr_en)
    else $error("array written on suspended edge");
endmodule : sram_port
`default_nettype wire

/* verif/sram_host_model.sv */
// host-side data pin model: puts write data on the pins two cycles after each write cycle
// assumes inputs change by nba at rising edges of the shared clock
`timescale 1ns/1ps
`default_nettype none
module sram_host_model
  import sram_port_pkg::*;
(
  // clock and suspend
  input  wire logic              clk_sys_i,
  input  wire logic              susp_i,
  // cycle request
  input  wire logic              go_i,
  input  wire logic [WORD_W-1:0] wdata_i,
  // data pins
  output logic      [WORD_W-1:0] pins_o
);
  logic [1:0]        v_q    = 2'h0;
  logic [WORD_W-1:0] d1_q   = 18'h00000;
  logic [WORD_W-1:0] d2_q   = 18'h00000;
  logic [WORD_W-1:0] last_q = 18'h00000;
  always_ff @(posedge clk_sys_i) begin
    if (!susp_i) begin
      v_q    <= {v_q[0], go_i};
      d1_q   <= wdata_i;
      d2_q   <= d1_q;
      last_q <= pins_o;
    end
  end
  // released bus toggles so a late or early sample sees wrong data
  assign pins_o = v_q[1] ? d2_q : ~last_q;
endmodule : sram_host_model
`default_nettype wire

/* verif/tb.sv */
// bench for the sram port: pin-level load, advance, select and suspend sequences
// assumes sram_host_model supplies write data on the data pins
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sram_port_pkg::*;
  localparam logic [4:0] LW = 5'h00, LR = 5'h01, AD = 5'h03, SU = 5'h10;
  logic              clk_sys_i = 1'b0;
  logic              rst_n_i   = 1'b0;
  logic              susp = 1'b0, ld_n = 1'b1, wr_n = 1'b1, go = 1'b0, mode = 1'b0;
  logic              cs_n = 1'b0, cs_hi = 1'b1, cs_alt_n = 1'b0, md = 1'b0;
  logic              oe_n, soe, ps = 1'b0;
  logic [ADDR_W-1:0] addr = 19'h00000;
  logic [1:0]        bw_n = 2'h0, pk = 2'h0, ek [3] = '{default: 2'h0};
  logic [WORD_W-1:0] wd = 18'h00000, sv, pv, ev [3];
  wire  [WORD_W-1:0] pins, rd;
  int                fail_count = 0;
  int                check_count = 0;
  always #(CLK_PERIOD_NS / 2) clk_sys_i = ~clk_sys_i;
  //////////////////////////////////////////////////////////////////////////////
  sram_host_model sram_host_model_inst (.clk_sys_i(clk_sys_i), .susp_i(susp), .go_i(go),
    .wdata_i(wd), .pins_o(pins));
  sram_port sram_port_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .clock_suspend_n_i(susp), .advance_or_load_n_i(ld_n), .write_n_i(wr_n),
    .chip_select_n_i(cs_n), .chip_select_hi_i(cs_hi), .chip_select_alt_n_i(cs_alt_n),
    .burst_interleaved_i(mode), .addr_i(addr), .lane0_byte_write_n_i(bw_n[0]),
    .lane1_byte_write_n_i(bw_n[1]), .lane0_data_i(pins[8:0]), .lane1_data_i(pins[17:9]),
    .lane0_data_o(rd[8:0]), .lane1_data_o(rd[17:9]), .data_oe_n_o(oe_n));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [WORD_W-1:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // m = {suspend, dropped select, load_n, write_n}; k: 1 write, 2 read, 3 bus floats
  task automatic op(input logic [4:0] m, input logic [ADDR_W-1:0] a, input logic [1:0] b,
                    input logic [WORD_W-1:0] d, input logic [1:0] k);
    @(posedge clk_sys_i);
    susp     <= m[4];
    cs_n     <= (m[3:2] == 2'h1);
    cs_hi    <= (m[3:2] != 2'h2);
    cs_alt_n <= (m[3:2] == 2'h3);
    ld_n     <= m[1];
    wr_n     <= m[0];
    addr     <= a;
    bw_n     <= b;
    wd       <= d;
    go       <= (k == 2'h1);
    mode     <= md;
    @(negedge clk_sys_i);
    if (ps) begin
      check("held data", rd, sv);
      check("held oe", 18'(oe_n), 18'(soe));
    end else begin
      ev[2] = ev[1];
      ek[2] = ek[1];
      ev[1] = ev[0];
      ek[1] = ek[0];
      ev[0] = pv;
      ek[0] = pk;
      if (ek[2] == 2'h2) check("read data", rd, ev[2]);
      if (ek[2] != 2'h0) check("oe", 18'(oe_n), 18'(ek[2] != 2'h2));
    end
    ps = m[4];
    sv = rd;
    soe = oe_n;
    if (!m[4]) begin
      pv = d;
      pk = k;
    end
  endtask : op
  task automatic done(input string n);
    $display("test %s done", n);
  endtask : done
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_sys_i);
    check("reset oe", 18'(oe_n), 18'h00001);
    check("reset data", rd, WORD_RST);
    rst_n_i <= 1'b1;
    // linear burst from offset 1, advances carry junk address and read select
    op(LW, 19'h00005, 2'h0, 18'h11111, 2'h1);
    op(AD, 19'h7ffff, 2'h0, 18'h22222, 2'h1);
    op(AD, 19'h7ffff, 2'h0, 18'h23456, 2'h1);
    op(AD, 19'h7ffff, 2'h0, 18'h3abcd, 2'h1);
    // lane-selective writes
    op(LW, 19'h00005, 2'h2, 18'h3ffff, 2'h1);
    op(LW, 19'h00006, 2'h1, 18'h00000, 2'h1);
    // each select dropped in turn, carrying a write that must not land
    for (int c = 1; c < 4; c++) begin
      op(5'(c * 4), 19'h00004, 2'h0, 18'h15555, 2'h3);
    end
    op(AD, 19'h00000, 2'h0, 18'h00000, 2'h3);
    done("write");
    // interleaved read burst from offset 2 with a suspended edge inside
    md = 1'b1;
    op(LR, 19'h00006, 2'h0, 18'h00022, 2'h2);
    op(SU, 19'h00001, 2'h0, 18'h3ffff, 2'h0);
    op(AD, 19'h00000, 2'h0, 18'h23456, 2'h2);
    op(AD, 19'h00000, 2'h0, 18'h3abcd, 2'h2);
    op(AD, 19'h00000, 2'h0, 18'h111ff, 2'h2);
    op(LR, 19'h00046, 2'h3, 18'h00022, 2'h2);
    repeat (6) op(5'h04, 19'h00000, 2'h0, 18'h00000, 2'h3);
    done("read");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
